/* File: logic/fca_alu.v */
// Purpose: execution datapath for flip-carry, zero-fill, invert, compare
// Assumes: decoder presents one instruction at a time; AHB-Lite slave
// Notes: every instruction takes four cycles from accept to done pulse
`timescale 1ns/100ps
`include "fca_defs.vh"

// Behaviour
// - flip-carry, opcode ef, one byte, four cycles, inverts the carry flag
// - flip-carry leaves every other flag bit as it was
// - flag word lives at register address d5, in the register space
// - zero-fill writes 00 to its destination and touches no flag
// - zero-fill: two bytes, four cycles; b0 direct, b1 through a pointer
// - invert writes the one's complement of the destination back
// - invert: two bytes, four cycles; 60 direct, 61 through a pointer
// - invert sets zero and sign from result, clears overflow, keeps others
// - compare subtracts source from destination, writes neither operand
// - compare sets carry on borrow, source above destination
// - compare sets zero and sign from the difference, keeps others
// - compare overflow: opposite operand signs, result signed as source
module fca_alu (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // instruction from the decoder
  input wire ins_valid,
  input wire [7:0] ins_opcode,
  input wire [7:0] ins_dst,
  input wire [7:0] ins_src,
  output reg ins_ready,
  output reg ins_done,
  output reg [1:0] ins_bytes,
  // flag word to the rest of the core
  output reg [7:0] status_flag_word,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RD1 = 2'h1;
  localparam ST_RD2 = 2'h2;
  localparam ST_EXE = 2'h3;

  reg [1:0] state;
  reg [1:0] op_kind;
  reg op_ind;
  reg op_ok;
  reg [7:0] op_code;
  reg [7:0] op_dst;
  reg [7:0] op_src;
  reg [7:0] d1;
  reg [7:0] last_rd_addr;
  reg wr_en;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg bad_op;
  reg ap_valid;
  reg ap_write;
  reg [11:0] ap_addr;

  reg [7:0] rd_addr;
  reg [1:0] dec_kind;
  reg dec_ind;
  reg dec_ok;
  reg [1:0] dec_len;
  reg [7:0] base_flags;
  reg [7:0] next_flags;
  reg [31:0] rd_mux;
  wire [7:0] mem_rd;
  wire [7:0] rd_q;
  wire [7:0] dval;
  wire [7:0] target;
  wire [7:0] calc_result;
  wire calc_wr;
  wire [7:0] calc_flags;
  wire accept;
  wire ap_take;
  wire bus_flag_wr;
  wire bus_stat_wr;

  assign accept = ins_ready & ins_valid;
  assign ap_take = hsel & hready & htrans[1];
  assign bus_flag_wr = ap_valid & ap_write &
    (ap_addr == `FCA_FLAGS_ADDR);
  assign bus_stat_wr = ap_valid & ap_write &
    (ap_addr == `FCA_STAT_ADDR);

  // opcode decode
  always @* begin
    dec_kind = `FCA_K_FLIP;
    dec_ind = 1'b0;
    dec_ok = 1'b1;
    dec_len = `FCA_LEN_TWO;
    case (ins_opcode)
      `FCA_OP_FLIP: begin
        dec_kind = `FCA_K_FLIP;
        dec_len = `FCA_LEN_FLIP;
      end
      `FCA_OP_ZERO_R: begin
        dec_kind = `FCA_K_ZERO;
      end
      `FCA_OP_ZERO_IR: begin
        dec_kind = `FCA_K_ZERO;
        dec_ind = 1'b1;
      end
      `FCA_OP_INV_R: begin
        dec_kind = `FCA_K_INV;
      end
      `FCA_OP_INV_IR: begin
        dec_kind = `FCA_K_INV;
        dec_ind = 1'b1;
      end
      `FCA_OP_CMP: begin
        dec_kind = `FCA_K_CMP;
        dec_len = `FCA_LEN_CMP;
      end
      default: begin
        dec_ok = 1'b0;
        dec_len = `FCA_LEN_FLIP;
      end
    endcase
  end

  // read address per step: first the destination or its pointer,
  // then the pointed-to register or the source
  always @* begin
    case (state)
      ST_RD1: rd_addr = op_dst;
      ST_RD2: rd_addr = op_ind ? rd_q : op_src;
      default: rd_addr = op_dst;
    endcase
  end

  // the flag word answers reads at its register address
  assign rd_q = (last_rd_addr == `FCA_FLAGS_IDX) ? status_flag_word : mem_rd;
  assign dval = op_ind ? rd_q : d1;
  assign target = op_ind ? d1 : op_dst;

  fca_regfile u_regfile (
    .sys_clk(sys_clk),
    .rd_addr(rd_addr),
    .rd_data(mem_rd),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // a write aimed at the flag word lands there, then flags overlay it
  always @* begin
    base_flags = status_flag_word;
    if (bus_flag_wr) begin
      base_flags = hwdata[7:0];
    end
    if (calc_wr && target == `FCA_FLAGS_IDX) begin
      base_flags = calc_result;
    end
  end

  fca_calc u_calc (
    .kind(op_kind),
    .dval(dval),
    .sval(rd_q),
    .flags_in(base_flags),
    .result(calc_result),
    .wr(calc_wr),
    .flags_out(calc_flags) // bit layout fixed in the defs header
  );

  // instruction update wins over a bus write in the same cycle;
  // an unknown opcode rides the flip slot but must not flip the carry
  always @* begin
    next_flags = status_flag_word;
    if (state == ST_EXE && op_ok) begin
      next_flags = calc_flags;
    end else if (bus_flag_wr) begin
      next_flags = hwdata[7:0];
    end
  end

  // sequencer: accept, read, read, execute; done follows the execute edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op_kind <= `FCA_K_FLIP;
      op_ind <= 1'b0;
      op_ok <= 1'b0;
      op_code <= 8'h00;
      op_dst <= 8'h00;
      op_src <= 8'h00;
      d1 <= 8'h00;
      last_rd_addr <= 8'h00;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      ins_ready <= 1'b1;
      ins_done <= 1'b0;
      ins_bytes <= 2'h0;
      status_flag_word <= `FCA_FLAGS_RST;
    end else begin
      last_rd_addr <= rd_addr;
      status_flag_word <= next_flags;
      wr_en <= 1'b0;
      ins_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // ready only after the last write has landed
          ins_ready <= 1'b1;
          if (accept) begin
            ins_ready <= 1'b0;
            op_kind <= dec_ok ? dec_kind : `FCA_K_FLIP;
            op_ind <= dec_ind;
            op_ok <= dec_ok;
            op_code <= ins_opcode;
            op_dst <= ins_dst;
            op_src <= ins_src;
            ins_bytes <= dec_len;
            state <= dec_ok ? ST_RD1 : ST_RD1;
          end
        end
        ST_RD1: begin
          state <= ST_RD2;
        end
        ST_RD2: begin
          d1 <= rd_q;
          state <= ST_EXE;
        end
        ST_EXE: begin
          // flag word is never mirrored into the register file
          wr_en <= calc_wr & (target != `FCA_FLAGS_IDX) &
            (op_code != 8'h00 || op_kind != `FCA_K_FLIP);
          wr_addr <= target;
          wr_data <= calc_result;
          ins_done <= 1'b1; // fourth cycle after accept
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // unknown opcodes run the four-cycle frame with no effect and are
  // reported; they reuse the flip slot, so the flags must be protected
  // here: the sticky bit is set on accept, write one to clear, set wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_op <= 1'b0;
    end else if (accept && !dec_ok) begin
      bad_op <= 1'b1;
    end else if (bus_stat_wr && hwdata[`FCA_ST_BADOP]) begin
      bad_op <= 1'b0;
    end
  end

  // bus read data
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[11:0])
      `FCA_FLAGS_ADDR: rd_mux = {24'h00_0000, status_flag_word};
      `FCA_STAT_ADDR: begin
        rd_mux[`FCA_ST_BUSY] = ~ins_ready;
        rd_mux[`FCA_ST_BADOP] = bad_op;
        rd_mux[`FCA_ST_OP_LO +: 8] = op_code;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
    if (|haddr[31:12]) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ahb-lite slave: zero wait states, read data captured at the address
  // phase edge so it stands through the whole data phase
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        ap_valid <= ap_take & ~(|haddr[31:12]);
        ap_write <= hwrite;
        ap_addr <= haddr[11:0];
        if (ap_take && !hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end
endmodule

/* File: logic/fca_calc.v */
// Purpose: result and flag arithmetic for the four operations
// Assumes: kind encoded as in fca_defs.vh
// Notes: purely combinational
`timescale 1ns/100ps
`include "fca_defs.vh"
module fca_calc (
  // operation
  input wire [1:0] kind,
  input wire [7:0] dval,
  input wire [7:0] sval,
  input wire [7:0] flags_in,
  // results
  output reg [7:0] result,
  output reg wr,
  output reg [7:0] flags_out
);
  reg [8:0] diff;

  always @* begin
    diff = {1'b0, dval} - {1'b0, sval};
    result = 8'h00;
    wr = 1'b0;
    flags_out = flags_in;
    case (kind)
      `FCA_K_FLIP: begin
        // only the carry moves
        flags_out[`FCA_F_CARRY] = ~flags_in[`FCA_F_CARRY];
      end
      `FCA_K_ZERO: begin
        result = 8'h00; // flags left alone
        wr = 1'b1;
      end
      `FCA_K_INV: begin
        result = ~dval;
        wr = 1'b1;
        flags_out[`FCA_F_ZERO] = (~dval == 8'h00);
        flags_out[`FCA_F_SIGN] = ~dval[7];
        flags_out[`FCA_F_OVF] = 1'b0;
      end
      `FCA_K_CMP: begin
        // difference only feeds flags, nothing is written
        flags_out[`FCA_F_CARRY] = diff[8];
        flags_out[`FCA_F_ZERO] = (diff[7:0] == 8'h00);
        flags_out[`FCA_F_SIGN] = diff[7];
        flags_out[`FCA_F_OVF] = (dval[7] ^ sval[7]) &
          (diff[7] == sval[7]);
      end
      default: begin
        wr = 1'b0;
      end
    endcase
  end
endmodule

/* File: logic/fca_defs.vh */
// Purpose: shared constants of the flag/clear/invert/compare datapath
// Assumes: plain Verilog-2005, included by bare name
// Notes: definitions only
`ifndef FCA_DEFS_VH
`define FCA_DEFS_VH

// register bus map (index of the flag word is its register address)
`define FCA_FLAGS_IDX 8'hd5
`define FCA_FLAGS_ADDR 12'h354
`define FCA_STAT_ADDR 12'h358
`define FCA_FLAGS_RST 8'h00

// status word fields
`define FCA_ST_BUSY 0
`define FCA_ST_BADOP 1
`define FCA_ST_OP_LO 8

// flag bit positions inside the flag word
`define FCA_F_CARRY 7
`define FCA_F_ZERO 6
`define FCA_F_SIGN 5
`define FCA_F_OVF 4
`define FCA_F_DEC 3
`define FCA_F_HALF 2

// opcodes
`define FCA_OP_FLIP 8'hef
`define FCA_OP_ZERO_R 8'hb0
`define FCA_OP_ZERO_IR 8'hb1
`define FCA_OP_INV_R 8'h60
`define FCA_OP_INV_IR 8'h61
`define FCA_OP_CMP 8'ha4

// operation kinds inside the datapath
`define FCA_K_FLIP 2'h0
`define FCA_K_ZERO 2'h1
`define FCA_K_INV 2'h2
`define FCA_K_CMP 2'h3

// instruction cycles and lengths in bytes
`define FCA_INS_CYCLES 4
`define FCA_LEN_FLIP 2'h1
`define FCA_LEN_TWO 2'h2
`define FCA_LEN_CMP 2'h3

`endif

/* File: logic/fca_regfile.v */
// Purpose: 256 x 8 register file behind the datapath
// Assumes: one read and one write port, both on sys_clk
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/100ps
module fca_regfile (
  // clock
  input wire sys_clk,
  // read port
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data,
  // write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data
);
  reg [7:0] mem [0:255];

  // no reset: contents are software-defined, like any register file
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: sim/fca_alu_asserts.sv */
// Purpose: port checks of fca_alu
// Assumes: no bus write while an instruction runs
// Notes: flag effects seen one edge after the update edge
`timescale 1ns/100ps
`include "fca_defs.vh"
module fca_alu_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // instruction side
  input wire ins_valid,
  input wire [7:0] ins_opcode,
  input wire [7:0] ins_dst,
  input wire ins_ready,
  input wire ins_done,
  input wire [1:0] ins_bytes,
  input wire [7:0] status_flag_word,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire acc = ins_valid && ins_ready;
  wire [7:0] op = ins_opcode;
  wire [7:0] f = status_flag_word;
  // flag word as destination overlays the result, so skip it here
  wire dir = ins_dst != `FCA_FLAGS_IDX;
  wire inv = op == `FCA_OP_INV_R || op == `FCA_OP_INV_IR;
  wire zer = op == `FCA_OP_ZERO_R || op == `FCA_OP_ZERO_IR;
  wire rd = hsel && hready && htrans[1] && !hwrite;
  AST_DONE_LAT: assert property (acc |=> !ins_ready [*3] ##1 ins_done)
    else $error("done not four cycles after accept");
  AST_ONE_PULSE: assert property (ins_done |=> !ins_done)
    else $error("done longer than one cycle");
  AST_READY_BACK: assert property (ins_done |-> ##1 ins_ready)
    else $error("ready not back after done");
  AST_LEN: assert property (acc |=> ins_bytes == $past(zer || inv ?
    `FCA_LEN_TWO : op == `FCA_OP_CMP ? `FCA_LEN_CMP : `FCA_LEN_FLIP))
    else $error("wrong instruction length");
  AST_FLIP: assert property (acc && op == `FCA_OP_FLIP ##4 1 |->
    f == ($past(f) ^ 8'h80)) else $error("flip changed wrong bits");
  AST_ZERO: assert property (acc && op == `FCA_OP_ZERO_R && dir |=>
    $stable(f) [*4]) else $error("zero fill touched flags");
  AST_INV: assert property (acc && inv && dir ##4 1 |-> !f[4] &&
    f[7] == $past(f[7]) && f[3:2] == $past(f[3:2]))
    else $error("invert flag effect wrong");
  AST_CMP: assert property (acc && op == `FCA_OP_CMP ##4 1 |->
    f[3:2] == $past(f[3:2])) else $error("compare changed kept flags");
  AST_BUS_RD: assert property (rd && haddr == {20'h0, `FCA_FLAGS_ADDR}
    |=> hrdata == {24'h0, $past(f)}) else $error("flag word read wrong");
endmodule
bind fca_alu fca_alu_chk fca_alu_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .ins_valid(ins_valid), .ins_opcode(ins_opcode), .ins_dst(ins_dst),
  .ins_ready(ins_ready), .ins_done(ins_done), .ins_bytes(ins_bytes),
  .status_flag_word(status_flag_word), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata));

/* File: sim/fca_dec_model.sv */
// Purpose: decoder side that offers instructions to fca_alu
// Assumes: called just after a rising edge
// Notes: operands scrambled once taken, so late sampling shows up
`timescale 1ns/100ps
module fca_dec_model (
  // clock
  input wire sys_clk,
  // instruction port
  input wire ins_ready,
  output logic ins_valid,
  output logic [7:0] ins_opcode,
  output logic [7:0] ins_dst,
  output logic [7:0] ins_src
);
  initial begin
    ins_valid = 1'b0;
    ins_opcode = 8'h00;
    ins_dst = 8'h00;
    ins_src = 8'h00;
  end
  task automatic issue(input logic [7:0] o, d, s, input int stall);
    begin
      repeat (stall) @(posedge sys_clk);
      ins_valid <= 1'b1;
      ins_opcode <= o;
      ins_dst <= d;
      ins_src <= s;
      do @(posedge sys_clk); while (ins_ready !== 1'b1);
      ins_valid <= 1'b0;
      ins_opcode <= ~o;
      ins_dst <= ~d;
      ins_src <= ~s;
    end
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench of fca_alu
// Assumes: register file starts unknown, so cells are zero-filled first
// Notes: flags tracked in the bench, never read back as expectation
`timescale 1ns/100ps
`include "fca_defs.vh"
module tb;
  logic sys_clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  wire ins_valid;
  wire ins_ready;
  wire ins_done;
  wire [1:0] ins_bytes;
  wire [7:0] op;
  wire [7:0] dst;
  wire [7:0] src;
  wire [7:0] flags;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  integer seed = 32'he3bf;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [31:0] w;
  logic [7:0] f;
  logic [7:0] s;
  fca_alu fca_alu_i (.sys_clk(sys_clk), .rst_n(rst_n), .ins_valid(ins_valid),
    .ins_opcode(op), .ins_dst(dst), .ins_src(src), .ins_ready(ins_ready),
    .ins_done(ins_done), .ins_bytes(ins_bytes), .status_flag_word(flags),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  fca_dec_model fca_dec_model_i (.sys_clk(sys_clk), .ins_ready(ins_ready),
    .ins_valid(ins_valid), .ins_opcode(op), .ins_dst(dst), .ins_src(src));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    begin
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // whole run is about 240 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, e);
    begin
      n_tests++;
      if (g !== e) begin
        fails++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  function automatic logic [7:0] exp_inv(input logic [7:0] r, fl);
    exp_inv = {fl[7], r == 8'h00, r[7], 1'b0, fl[3:0]};
  endfunction
  function automatic logic [7:0] exp_cmp(input logic [7:0] d, sv, fl);
    logic [7:0] df;
    df = d - sv;
    exp_cmp = {sv > d, df == 8'h00, df[7],
      d[7] != sv[7] && df[7] == sv[7], fl[3:0]};
  endfunction
  function automatic logic [1:0] exp_len(input logic [7:0] o);
    case (o)
      `FCA_OP_FLIP: exp_len = `FCA_LEN_FLIP;
      `FCA_OP_ZERO_R, `FCA_OP_ZERO_IR, `FCA_OP_INV_R, `FCA_OP_INV_IR:
        exp_len = `FCA_LEN_TWO;
      `FCA_OP_CMP: exp_len = `FCA_LEN_CMP;
      default: exp_len = `FCA_LEN_FLIP;
    endcase
  endfunction
  task run(input logic [7:0] o, d, sr, ef);
    int n;
    begin
      fca_dec_model_i.issue(o, d, sr, {$random(seed)} % 3);
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (ins_done !== 1'b1 && n < 9);
      chk(n, 4);
      chk(ins_bytes, exp_len(o));
      chk(flags, ef);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 32'h354, 32'h0);
    chk(rd, 32'h0);
    chk(ins_ready, 1);
    bus(1'b0, 32'h1000, 32'h0);
    chk(rd, 32'h0);
    $display("reset and map done");
    repeat (4) begin
      w = $random(seed);
      bus(1'b1, 32'h354, w);
      bus(1'b0, 32'h354, 32'h0);
      chk(rd, {24'h0, w[7:0]});
      run(`FCA_OP_FLIP, 8'h00, 8'h00, w[7:0] ^ 8'h80);
    end
    $display("flip done");
    f = $random(seed);
    bus(1'b1, 32'h354, {24'h0, f});
    run(`FCA_OP_ZERO_R, 8'h10, 8'h0, f);
    f = exp_inv(8'hff, f);
    run(`FCA_OP_INV_R, 8'h10, 8'h0, f);
    f = exp_inv(8'h00, f);
    run(`FCA_OP_INV_R, 8'h10, 8'h0, f);
    run(`FCA_OP_ZERO_R, 8'h30, 8'h0, f);
    f = exp_inv(8'hff, f);
    run(`FCA_OP_INV_R, 8'h30, 8'h0, f);
    run(`FCA_OP_ZERO_R, 8'hff, 8'h0, f);
    f = exp_inv(8'hff, f);
    run(`FCA_OP_INV_IR, 8'h30, 8'h0, f);
    run(`FCA_OP_ZERO_IR, 8'h30, 8'h0, f);
    f = exp_inv(8'hff, f);
    run(`FCA_OP_INV_R, 8'hff, 8'h0, f);
    $display("clear and invert done");
    for (int i = 0; i < 8; i++) begin
      f = i == 0 ? 8'h00 : i == 1 ? 8'h7f : $random(seed);
      s = i[0] ? 8'hff : 8'h00;
      bus(1'b1, 32'h354, {24'h0, f});
      f = exp_cmp(f, s, f);
      run(`FCA_OP_CMP, 8'hd5, i[0] ? 8'h30 : 8'h10, f);
      f = exp_cmp(8'h00, f, f);
      run(`FCA_OP_CMP, 8'h10, 8'hd5, f);
    end
    // unknown opcode: four-cycle frame, flags kept, sticky status bit
    run(8'h5a, 8'h10, 8'h10, f);
    bus(1'b0, 32'h358, 32'h0);
    chk(rd, 32'h0000_5a02);
    bus(1'b1, 32'h358, 32'h2);
    bus(1'b0, 32'h358, 32'h0);
    chk(rd, 32'h0000_5a00);
    chk(hresp, 0);
    $display("compare done");
    report_and_stop;
  end
endmodule
